// ===== mst_pkg.sv
package mst_pkg;

  // Parameter addresses as seen by the fieldbus parameter port.
  localparam logic [15:0] ADDR_START_RECORD = 16'h1B14;
  localparam logic [15:0] ADDR_END_SEQ_SEL  = 16'h2D12;
  localparam logic [15:0] ADDR_FALL_RESP    = 16'h2D18;
  localparam logic [15:0] ADDR_RECORD_TYPE  = 16'h2D22;
  localparam logic [15:0] ADDR_TRANS_TYPE   = 16'h2D2C;
  localparam logic [15:0] ADDR_NEXT_RECORD  = 16'h2D2E;
  localparam logic [15:0] ADDR_COND1_KIND   = 16'h2D30;
  localparam logic [15:0] ADDR_COND1_VALUE  = 16'h2D32;
  localparam logic [15:0] ADDR_COND2_KIND   = 16'h2D38;
  localparam logic [15:0] ADDR_COND2_VALUE  = 16'h2D3A;

  // Reset values.
  localparam logic [6:0]  RST_START_RECORD = 7'h00;
  localparam logic        RST_END_SEQ_SEL  = 1'h0;
  localparam logic        RST_FALL_RESP    = 1'h0;
  localparam logic [3:0]  RST_RECORD_TYPE  = 4'h0;
  localparam logic [2:0]  RST_TRANS_TYPE   = 3'h0;
  localparam logic [6:0]  RST_NEXT_RECORD  = 7'h00;
  localparam logic [1:0]  RST_COND_KIND    = 2'h0;
  localparam logic [31:0] RST_COND_VALUE   = 32'h0000_0000;

  // Legal ranges.
  localparam logic [31:0] MAX_RECORD_NUM  = 32'h0000_007F;
  localparam logic [31:0] MAX_RECORD_TYPE = 32'h0000_0009;
  localparam logic [31:0] GAP_RECORD_TYPE = 32'h0000_0008;
  localparam logic [31:0] MAX_TRANS_TYPE  = 32'h0000_0004;
  localparam logic [31:0] MAX_COND_KIND   = 32'h0000_0003;
  localparam logic [31:0] MAX_OPTION      = 32'h0000_0001;

  // Condition values for edge and level kinds.
  localparam logic [31:0] CV_RISE  = 32'h0000_0000;
  localparam logic [31:0] CV_FALL  = 32'h0000_0001;
  localparam logic [31:0] CV_HIGH  = 32'h0000_0002;
  localparam logic [31:0] CV_LOW   = 32'h0000_0003;
  localparam logic [31:0] CV_EITHER = 32'h0000_0004;

  // Timing.
  localparam int          SYS_CLK_KHZ   = 250000;
  localparam int          WAIT_UNIT_MS  = 1;
  localparam int          CYCLES_PER_MS = SYS_CLK_KHZ * WAIT_UNIT_MS;
  localparam int          PRESCALE_W    = 18;
  localparam logic [31:0] WAIT_MAX_MS   = 32'h0000_7530;

  typedef enum logic [3:0] {
    MST_REC_NONE  = 4'h0,
    MST_REC_ABS   = 4'h1,
    MST_REC_ADD   = 4'h2,
    MST_REC_REF   = 4'h3,
    MST_REC_POS   = 4'h4,
    MST_REC_REP   = 4'h5,
    MST_REC_REL   = 4'h6,
    MST_REC_VEL   = 4'h7,
    MST_REC_PARAM = 4'h9
  } mst_rec_type;

  typedef enum logic [1:0] {
    MST_COND_UNCOND = 2'h0,
    MST_COND_WAIT   = 2'h1,
    MST_COND_EDGE   = 2'h2,
    MST_COND_LEVEL  = 2'h3
  } mst_cond_type;

  typedef enum logic [2:0] {
    MST_TR_NONE   = 3'h0,
    MST_TR_ABORT  = 3'h1,
    MST_TR_BUFFER = 3'h2,
    MST_TR_BLPREV = 3'h3,
    MST_TR_BLNEXT = 3'h4
  } mst_trans_type;

  typedef enum logic [2:0] {
    MST_ST_IDLE  = 3'b000,
    MST_ST_MOVE  = 3'b001,
    MST_ST_COND1 = 3'b011,
    MST_ST_COND2 = 3'b010,
    MST_ST_END   = 3'b110
  } mst_state_type;

  typedef struct packed {
    logic [3:0]  rtype;
    logic [2:0]  trans;
    logic [6:0]  next_rec;
    logic [1:0]  kind1;
    logic [31:0] val1;
    logic [1:0]  kind2;
    logic [31:0] val2;
  } mst_record_type;

endpackage

// ===== mst_sync.sv
`timescale 1ns/1ps
module mst_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_sync_out;

  // A bit is accepted only once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ===== mst_core.sv
`timescale 1ns/1ps
module mst_core
  import mst_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  input  wire logic        power_stage_on,
  input  wire logic        mode_on,
  input  wire logic        motion_done,
  input  wire logic        start_pin,
  input  wire logic [6:0]  select_pin,
  output logic      [6:0]  active_record,
  output mst_rec_type      record_kind,
  output logic             move_start,
  output logic             move_cancel,
  output logic             sequence_end,
  output logic             seq_busy
);

  mst_record_type rec;
  mst_record_type next_rec;
  logic [6:0]     start_record;
  logic [6:0]     next_start_record;
  logic           end_seq_sel;
  logic           next_end_seq_sel;
  logic           fall_resp;
  logic           next_fall_resp;
  logic [31:0]    next_par_rdata;
  logic           next_par_ack;
  logic           next_par_err;
  logic [7:0]     sync_bus;
  logic           start_lvl;
  logic           start_prev;
  logic           start_rise;
  logic           start_fall;
  mst_state_type          state;
  mst_state_type          next_state;
  logic [6:0]             pending;
  logic [6:0]             next_pending;
  logic                   seeded;
  logic                   next_seeded;
  logic [6:0]             next_active_record;
  logic [PRESCALE_W-1:0]  pre;
  logic [PRESCALE_W-1:0]  next_pre;
  logic [31:0]            ms_cnt;
  logic [31:0]            next_ms_cnt;
  logic                   next_move_start;
  logic                   next_move_cancel;
  logic                   next_sequence_end;
  logic                   ms_tick;
  logic [31:0]            wait_limit;
  logic                   cond1_met;
  logic                   cond2_met;
  logic                   wr_ok;

  function automatic logic cond_met(input logic [1:0] kind, input logic [31:0] value, input logic allow_wait,
                                    input logic timer_done, input logic lvl, input logic rise, input logic fall);
    logic r;
    r = 1'b0;
    unique case (mst_cond_type'(kind))
      MST_COND_UNCOND: r = 1'b1;
      MST_COND_WAIT:   r = allow_wait ? timer_done : 1'b1;
      MST_COND_EDGE:   r = (value == CV_RISE && rise) || (value == CV_FALL && fall) ||
                           (value == CV_EITHER && (rise || fall));
      MST_COND_LEVEL:  r = (value == CV_HIGH && lvl) || (value == CV_LOW && !lvl);
    endcase
    return r;
  endfunction
  function automatic logic in_range(input logic [31:0] v, input logic [31:0] max);
    return v <= max;
  endfunction
  mst_sync #(.W (8)) u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in ({select_pin, start_pin}),
    .sync_out (sync_bus)
  );

  assign start_lvl  = sync_bus[0];
  assign start_rise = start_lvl && !start_prev;
  assign start_fall = !start_lvl && start_prev;
  // Parameter port: one-cycle answer, out-of-range or locked writes are refused with an error.
  always_comb begin
    next_rec          = rec;
    next_start_record = start_record;
    next_end_seq_sel  = end_seq_sel;
    next_fall_resp    = fall_resp;
    next_par_rdata    = par_rdata;
    next_par_ack      = par_wr || par_rd;
    next_par_err      = 1'b0;
    wr_ok             = 1'b0;
    if (par_wr) begin
      unique case (par_addr)
        ADDR_START_RECORD: wr_ok = in_range(par_wdata, MAX_RECORD_NUM);
        ADDR_END_SEQ_SEL,
        ADDR_FALL_RESP:    wr_ok = !power_stage_on && in_range(par_wdata, MAX_OPTION);
        ADDR_RECORD_TYPE:  wr_ok = in_range(par_wdata, MAX_RECORD_TYPE) && par_wdata != GAP_RECORD_TYPE;
        ADDR_TRANS_TYPE:   wr_ok = in_range(par_wdata, MAX_TRANS_TYPE);
        ADDR_NEXT_RECORD:  wr_ok = in_range(par_wdata, MAX_RECORD_NUM);
        ADDR_COND1_KIND:   wr_ok = in_range(par_wdata, MAX_COND_KIND);
        ADDR_COND2_KIND:   wr_ok = in_range(par_wdata, MAX_COND_KIND) && par_wdata != 32'(MST_COND_WAIT);
        ADDR_COND1_VALUE,
        ADDR_COND2_VALUE:  wr_ok = 1'b1;
        default:           wr_ok = 1'b0;
      endcase
      next_par_err = !wr_ok;
      if (wr_ok) begin
        unique case (par_addr)
          ADDR_START_RECORD: next_start_record = par_wdata[6:0];
          ADDR_END_SEQ_SEL:  next_end_seq_sel  = par_wdata[0];
          ADDR_FALL_RESP:    next_fall_resp    = par_wdata[0];
          ADDR_RECORD_TYPE:  next_rec.rtype    = par_wdata[3:0];
          ADDR_TRANS_TYPE:   next_rec.trans    = par_wdata[2:0];
          ADDR_NEXT_RECORD:  next_rec.next_rec = par_wdata[6:0];
          ADDR_COND1_KIND:   next_rec.kind1    = par_wdata[1:0];
          ADDR_COND2_KIND:   next_rec.kind2    = par_wdata[1:0];
          ADDR_COND1_VALUE:  next_rec.val1     = par_wdata;
          default:           next_rec.val2     = par_wdata;
        endcase
      end
    end else if (par_rd) begin
      unique case (par_addr)
        ADDR_START_RECORD: next_par_rdata = {25'h0, start_record};
        ADDR_END_SEQ_SEL:  next_par_rdata = {31'h0, end_seq_sel};
        ADDR_FALL_RESP:    next_par_rdata = {31'h0, fall_resp};
        ADDR_RECORD_TYPE:  next_par_rdata = {28'h0, rec.rtype};
        ADDR_TRANS_TYPE:   next_par_rdata = {29'h0, rec.trans};
        ADDR_NEXT_RECORD:  next_par_rdata = {25'h0, rec.next_rec};
        ADDR_COND1_KIND:   next_par_rdata = {30'h0, rec.kind1};
        ADDR_COND2_KIND:   next_par_rdata = {30'h0, rec.kind2};
        ADDR_COND1_VALUE:  next_par_rdata = rec.val1;
        ADDR_COND2_VALUE:  next_par_rdata = rec.val2;
        default: begin
          next_par_rdata = 32'h0000_0000;
          next_par_err   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rec          <= '{RST_RECORD_TYPE, RST_TRANS_TYPE, RST_NEXT_RECORD, RST_COND_KIND, RST_COND_VALUE,
                        RST_COND_KIND, RST_COND_VALUE};
      start_record <= RST_START_RECORD;
      end_seq_sel  <= RST_END_SEQ_SEL;
      fall_resp    <= RST_FALL_RESP;
      par_rdata    <= 32'h0000_0000;
      par_ack      <= 1'b0;
      par_err      <= 1'b0;
    end else begin
      rec          <= next_rec;
      start_record <= next_start_record;
      end_seq_sel  <= next_end_seq_sel;
      fall_resp    <= next_fall_resp;
      par_rdata    <= next_par_rdata;
      par_ack      <= next_par_ack;
      par_err      <= next_par_err;
    end
  end
  // Type decode is purely combinational, so a rewritten type shows on the next cycle.
  assign record_kind = mst_rec_type'(rec.rtype);
  assign ms_tick    = (pre == PRESCALE_W'(MS_CYCLES - 1));
  assign wait_limit = (rec.val1 > WAIT_MAX_MS) ? WAIT_MAX_MS : rec.val1;
  assign cond1_met  = cond_met(rec.kind1, rec.val1, 1'b1, ms_cnt >= wait_limit, start_lvl, start_rise, start_fall);
  assign cond2_met  = cond_met(rec.kind2, rec.val2, 1'b0, 1'b1, start_lvl, start_rise, start_fall);
  assign seq_busy   = (state != MST_ST_IDLE);
  always_comb begin
    next_state         = state;
    next_pending       = pending;
    next_seeded        = seeded;
    next_active_record = active_record;
    next_pre           = pre;
    next_ms_cnt        = ms_cnt;
    next_move_start    = 1'b0;
    next_move_cancel   = 1'b0;
    next_sequence_end  = 1'b0;
    if (state == MST_ST_COND1) begin
      next_pre = ms_tick ? '0 : PRESCALE_W'(pre + 1'b1);
      if (ms_tick && ms_cnt < WAIT_MAX_MS) begin
        next_ms_cnt = ms_cnt + 32'h0000_0001;
      end
    end
    if (!mode_on) begin
      next_state  = MST_ST_IDLE;
      next_seeded = 1'b0;
    end else begin
      unique case (state)
        MST_ST_IDLE: begin
          if (start_rise) begin
            next_active_record = seeded ? pending : start_record;
            next_move_start    = 1'b1;
            next_state         = MST_ST_MOVE;
          end
        end
        MST_ST_MOVE: begin
          // Done still reports the previous movement while the start pulse is out, so it is ignored then.
          if (start_fall && fall_resp) begin
            next_move_cancel = 1'b1;
            next_state       = MST_ST_END;
          end else if (rec.trans == MST_TR_NONE) begin
            if ((motion_done && !move_start) || rec.rtype == MST_REC_NONE) begin
              next_state = MST_ST_END;
            end
          end else if (rec.trans != MST_TR_BUFFER || (motion_done && !move_start) || rec.rtype == MST_REC_NONE) begin
            next_pre    = '0;
            next_ms_cnt = 32'h0000_0000;
            next_state  = MST_ST_COND1;
          end
        end
        MST_ST_COND1: begin
          if (cond1_met) begin
            next_state = MST_ST_COND2;
          end
        end
        MST_ST_COND2: begin
          if (cond2_met) begin
            next_active_record = rec.next_rec;
            next_move_cancel   = (rec.trans == MST_TR_ABORT);
            next_move_start    = 1'b1;
            next_state         = MST_ST_MOVE;
          end
        end
        MST_ST_END: begin
          next_sequence_end = 1'b1;
          next_seeded       = 1'b1;
          next_pending      = end_seq_sel ? rec.next_rec : sync_bus[7:1];
          next_state        = MST_ST_IDLE;
        end
        default: next_state = MST_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state         <= MST_ST_IDLE;
      pending       <= 7'h00;
      seeded        <= 1'b0;
      active_record <= 7'h00;
      pre           <= '0;
      ms_cnt        <= 32'h0000_0000;
      start_prev    <= 1'b0;
      move_start    <= 1'b0;
      move_cancel   <= 1'b0;
      sequence_end  <= 1'b0;
    end else begin
      state         <= next_state;
      pending       <= next_pending;
      seeded        <= next_seeded;
      active_record <= next_active_record;
      pre           <= next_pre;
      ms_cnt        <= next_ms_cnt;
      start_prev    <= start_lvl;
      move_start    <= next_move_start;
      move_cancel   <= next_move_cancel;
      sequence_end  <= next_sequence_end;
    end
  end
  property p_wait_holds;
    @(posedge sys_clk) disable iff (!nrst)
      (state == MST_ST_COND1 && rec.kind1 == MST_COND_WAIT && ms_cnt < wait_limit)
      |=> (state == MST_ST_COND1 || state == MST_ST_IDLE);
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("timed wait left early");
  property p_rise_edge;
    @(posedge sys_clk) disable iff (!nrst)
      (mode_on && state == MST_ST_COND2 && rec.kind2 == MST_COND_EDGE && rec.val2 == CV_RISE && start_rise)
      |=> (state == MST_ST_MOVE && move_start);
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge not taken");
  property p_low_level_waits;
    @(posedge sys_clk) disable iff (!nrst)
      (mode_on && state == MST_ST_COND2 && rec.kind2 == MST_COND_LEVEL && rec.val2 == CV_LOW && start_lvl)
      |=> state == MST_ST_COND2;
  endproperty
  a_low_level_waits: assert property (p_low_level_waits) else $error("low level wait passed on high");
  property p_uncond;
    @(posedge sys_clk) disable iff (!nrst)
      (mode_on && state == MST_ST_COND1 && rec.kind1 == MST_COND_UNCOND) |=> state == MST_ST_COND2;
  endproperty
  a_uncond: assert property (p_uncond) else $error("unconditional step stalled");
  property p_auto_next;
    @(posedge sys_clk) disable iff (!nrst)
      (mode_on && state == MST_ST_END && end_seq_sel) |=> (sequence_end && pending == $past(rec.next_rec));
  endproperty
  a_auto_next: assert property (p_auto_next) else $error("automatic next record wrong");
  property p_fall_cancel;
    @(posedge sys_clk) disable iff (!nrst)
      (mode_on && state == MST_ST_MOVE && start_fall && fall_resp) |=> (move_cancel ##1 sequence_end);
  endproperty
  a_fall_cancel: assert property (p_fall_cancel) else $error("falling edge did not cancel");
  property p_lock;
    @(posedge sys_clk) disable iff (!nrst)
      (par_wr && power_stage_on && (par_addr == ADDR_END_SEQ_SEL || par_addr == ADDR_FALL_RESP))
      |=> (par_err && par_ack && $stable(end_seq_sel) && $stable(fall_resp));
  endproperty
  a_lock: assert property (p_lock) else $error("locked option was written");
  property p_type_now;
    @(posedge sys_clk) disable iff (!nrst)
      (par_wr && par_addr == ADDR_RECORD_TYPE && par_wdata == 32'h0000_0007)
      |=> (record_kind == MST_REC_VEL && !par_err);
  endproperty
  a_type_now: assert property (p_type_now) else $error("record type not applied at once");
  property p_next_record;
    @(posedge sys_clk) disable iff (!nrst)
      (mode_on && state == MST_ST_COND2 && cond2_met) |=> (active_record == $past(rec.next_rec));
  endproperty
  a_next_record: assert property (p_next_record) else $error("subsequent record not started");

endmodule

// ===== mst_motion_model.sv
`timescale 1ns/1ps
module mst_motion_model #(
  parameter int DELAY = 3
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic stall,
  input  wire logic move_start,
  input  wire logic move_cancel,
  output logic      motion_done
);
  int   cnt;
  logic busy;

  // A stalled movement never finishes, so a cancel can overtake it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt         <= 0;
      busy        <= 1'b0;
      motion_done <= 1'b0;
    end else if (move_start) begin
      cnt         <= 0;
      busy        <= 1'b1;
      motion_done <= 1'b0;
    end else if (move_cancel) begin
      busy        <= 1'b0;
      motion_done <= 1'b0;
    end else if (busy && !stall) begin
      if (cnt == DELAY - 1) begin
        busy        <= 1'b0;
        motion_done <= 1'b1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ===== mst_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module mst_tb_top;
  import mst_pkg::*;
  logic        sys_clk;
  logic        nrst;
  logic        par_wr;
  logic        par_rd;
  logic [15:0] par_addr;
  logic [31:0] par_wdata;
  logic [31:0] par_rdata;
  logic        par_ack;
  logic        par_err;
  logic        power_stage_on;
  logic        mode_on;
  logic        motion_done;
  logic        start_pin;
  logic [6:0]  select_pin;
  logic [6:0]  active_record;
  mst_rec_type record_kind;
  logic        move_start;
  logic        move_cancel;
  logic        sequence_end;
  logic        seq_busy;
  logic        stall;
  int          checks;
  int          n_mismatch;
  int          n;
  int          hits;
  logic [31:0] codes [9] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h7, 32'h9};

  mst_core #(.MS_CYCLES(4)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
    .power_stage_on(power_stage_on), .mode_on(mode_on), .motion_done(motion_done),
    .start_pin(start_pin), .select_pin(select_pin), .active_record(active_record),
    .record_kind(record_kind), .move_start(move_start), .move_cancel(move_cancel),
    .sequence_end(sequence_end), .seq_busy(seq_busy)
  );

  mst_motion_model #(.DELAY(3)) model (
    .sys_clk(sys_clk), .nrst(nrst), .stall(stall), .move_start(move_start),
    .move_cancel(move_cancel), .motion_done(motion_done)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One access: request held across exactly one sampling edge, answer checked after it.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
    @(negedge sys_clk);
    par_wr = w;
    par_rd = !w;
    par_addr = a;
    par_wdata = d;
    @(negedge sys_clk);
    par_wr = 1'b0;
    par_rd = 1'b0;
    `CHK(par_ack, 1'b1)
    `CHK(par_err, e)
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 1'b0);
    `CHK(par_rdata, exp)
  endtask

  task automatic pin(input logic v);
    @(negedge sys_clk);
    start_pin = v;
  endtask

  // Waits for a pulse: 0 move start, 1 cancel, 2 sequence end.
  task automatic wait_ev(input int k, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim) begin
      @(negedge sys_clk);
      cnt++;
      hit = (k == 0) ? (move_start === 1'b1) : (k == 1) ? (move_cancel === 1'b1) : (sequence_end === 1'b1);
    end
    if (!hit) begin
      n_mismatch++;
      final_report();
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    {par_wr, par_rd, power_stage_on, mode_on, start_pin, stall} = 6'h00;
    par_addr = 16'h0000;
    par_wdata = 32'h0000_0000;
    select_pin = 7'h00;
    checks = 0;
    n_mismatch = 0;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    rd(ADDR_START_RECORD, 32'h0);
    rd(ADDR_FALL_RESP, 32'h0);
    rd(ADDR_RECORD_TYPE, 32'h0);
    foreach (codes[i]) begin
      acc(1'b1, ADDR_RECORD_TYPE, codes[i], 1'b0);
      `CHK(record_kind, codes[i][3:0])
    end
    acc(1'b1, ADDR_RECORD_TYPE, 32'h8, 1'b1);
    acc(1'b1, ADDR_RECORD_TYPE, 32'hA, 1'b1);
    rd(ADDR_RECORD_TYPE, 32'h9);
    for (int t = 0; t < 6; t++) begin
      acc(1'b1, ADDR_TRANS_TYPE, t, t > 4);
    end
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, ADDR_COND1_KIND, k, k > 3);
    end
    acc(1'b1, ADDR_COND2_KIND, 32'h1, 1'b1);
    acc(1'b1, ADDR_START_RECORD, 32'h80, 1'b1);
    acc(1'b1, ADDR_START_RECORD, 32'h7F, 1'b0);
    rd(ADDR_START_RECORD, 32'h7F);
    acc(1'b1, ADDR_NEXT_RECORD, 32'h80, 1'b1);
    power_stage_on = 1'b1;
    acc(1'b1, ADDR_END_SEQ_SEL, 32'h1, 1'b1);
    acc(1'b1, ADDR_FALL_RESP, 32'h1, 1'b1);
    rd(ADDR_FALL_RESP, 32'h0);
    power_stage_on = 1'b0;
    acc(1'b1, ADDR_FALL_RESP, 32'h1, 1'b0);
    acc(1'b1, ADDR_END_SEQ_SEL, 32'h1, 1'b0);
    acc(1'b0, 16'h0000, 32'h0, 1'b1);
    `CHK(par_rdata, 32'h0)
    // Timed wait then level-high condition.
    acc(1'b1, ADDR_START_RECORD, 32'h5, 1'b0);
    acc(1'b1, ADDR_RECORD_TYPE, 32'h1, 1'b0);
    acc(1'b1, ADDR_TRANS_TYPE, 32'h2, 1'b0);
    acc(1'b1, ADDR_NEXT_RECORD, 32'h9, 1'b0);
    acc(1'b1, ADDR_COND1_KIND, 32'h1, 1'b0);
    acc(1'b1, ADDR_COND1_VALUE, 32'h2, 1'b0);
    acc(1'b1, ADDR_COND2_KIND, 32'h3, 1'b0);
    acc(1'b1, ADDR_COND2_VALUE, CV_HIGH, 1'b0);
    mode_on = 1'b1;
    pin(1'b1);
    wait_ev(0, 20, n);
    `CHK(active_record, 7'h05)
    wait_ev(0, 60, n);
    `CHK(n >= 10, 1'b1)
    `CHK(active_record, 7'h09)
    acc(1'b1, ADDR_COND1_KIND, 32'h0, 1'b0);
    acc(1'b1, ADDR_COND1_VALUE, 32'h7530, 1'b0);
    wait_ev(0, 30, n);
    `CHK(n < 8, 1'b1)
    mode_on = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK(seq_busy, 1'b0)
    // Falling start edge cancels, then the next record comes from the end option.
    acc(1'b1, ADDR_TRANS_TYPE, 32'h0, 1'b0);
    acc(1'b1, ADDR_NEXT_RECORD, 32'h14, 1'b0);
    acc(1'b1, ADDR_COND2_KIND, 32'h0, 1'b0);
    stall = 1'b1;
    pin(1'b0);
    repeat (6) @(negedge sys_clk);
    mode_on = 1'b1;
    pin(1'b1);
    wait_ev(0, 20, n);
    `CHK(active_record, 7'h05)
    pin(1'b0);
    wait_ev(1, 20, n);
    wait_ev(2, 20, n);
    pin(1'b1);
    wait_ev(0, 20, n);
    `CHK(active_record, 7'h14)
    acc(1'b1, ADDR_END_SEQ_SEL, 32'h0, 1'b0);
    select_pin = 7'h21;
    pin(1'b0);
    wait_ev(1, 20, n);
    wait_ev(2, 20, n);
    pin(1'b1);
    wait_ev(0, 20, n);
    `CHK(active_record, 7'h21)
    // No cancel for response 0; second condition waits for a falling edge.
    acc(1'b1, ADDR_FALL_RESP, 32'h0, 1'b0);
    acc(1'b1, ADDR_TRANS_TYPE, 32'h2, 1'b0);
    acc(1'b1, ADDR_COND2_KIND, 32'h2, 1'b0);
    acc(1'b1, ADDR_COND2_VALUE, CV_FALL, 1'b0);
    stall = 1'b0;
    pin(1'b0);
    hits = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if (move_cancel === 1'b1) hits++;
    end
    `CHK(hits, 0)
    `CHK(move_start, 1'b0)
    pin(1'b1);
    hits = 0;
    repeat (10) begin
      @(negedge sys_clk);
      if (move_start === 1'b1) hits++;
    end
    `CHK(hits, 0)
    pin(1'b0);
    wait_ev(0, 20, n);
    `CHK(active_record, 7'h14)
    // Second condition: a low level must hold back while the input is high, then a rising edge moves on.
    pin(1'b1);
    acc(1'b1, ADDR_COND2_KIND, 32'h3, 1'b0);
    acc(1'b1, ADDR_COND2_VALUE, CV_LOW, 1'b0);
    hits = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if (move_start === 1'b1) hits++;
    end
    `CHK(hits, 0)
    acc(1'b1, ADDR_COND2_KIND, 32'h2, 1'b0);
    acc(1'b1, ADDR_COND2_VALUE, CV_RISE, 1'b0);
    pin(1'b0);
    hits = 0;
    repeat (8) begin
      @(negedge sys_clk);
      if (move_start === 1'b1) hits++;
    end
    `CHK(hits, 0)
    pin(1'b1);
    wait_ev(0, 20, n);
    `CHK(active_record, 7'h14)
    final_report();
  end
endmodule
